// [rtl/fpec_consts.vh]
`ifndef FPEC_CONSTS_VH
`define FPEC_CONSTS_VH

// ==========================================================================
// Device map
`define FPEC_FLASH_CONTROL_ADDR   16'hFE08
`define FPEC_PROTECT_START_ADDR   16'hFF7E
`define FPEC_ARRAY_BASE           16'hE000
`define FPEC_PROTECT_OPEN         8'hFF
`define FPEC_ERASED_BYTE          8'hFF
`define FPEC_VEC_RSVD_LO          16'hFFD4
`define FPEC_VEC_RSVD_HI          16'hFFDF

// ==========================================================================
// Device control bits
`define FPEC_BIT_PGM              0
`define FPEC_BIT_ERASE            1
`define FPEC_BIT_MASS             2
`define FPEC_BIT_HIGH_VOLTAGE_ENABLE             3

// ==========================================================================
// Controller register offsets (Wishbone byte addresses)
`define FPEC_REG_CMD              4'h0
`define FPEC_REG_ADDR             4'h4
`define FPEC_REG_DATA             4'h8
`define FPEC_REG_STAT             4'hC

// ==========================================================================
// Commands
`define FPEC_CMD_PAGE_ERASE       2'h1
`define FPEC_CMD_MASS_ERASE       2'h2
`define FPEC_CMD_PROGRAM          2'h3

// ==========================================================================
// Status bits
`define FPEC_ST_BUSY              0
`define FPEC_ST_DONE              1
`define FPEC_ST_REFUSED           2
`define FPEC_ST_NEED              3

// ==========================================================================
// Timing in ns and cycles at 25 ns
`define FPEC_CLK_NS               25
`define FPEC_T_NVS_NS             10000
`define FPEC_T_ERASE_NS           1000000
`define FPEC_T_MERASE_NS          4000000
`define FPEC_T_NVH_NS             5000
`define FPEC_T_NVHL_NS            100000
`define FPEC_T_PGS_NS             5000
`define FPEC_BYTE_PROGRAM_TIME_NS            30000
`define FPEC_T_RCV_NS             1000
`define FPEC_CYC(ns)              (((ns) + `FPEC_CLK_NS - 1) / `FPEC_CLK_NS)

`endif

// [rtl/fpec_host.v]
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`include "fpec_consts.vh"

module fpec_host
#(
    parameter T_ERASE_CYC  = `FPEC_CYC(`FPEC_T_ERASE_NS),
    parameter T_MERASE_CYC = `FPEC_CYC(`FPEC_T_MERASE_NS),
    parameter T_NVHL_CYC   = `FPEC_CYC(`FPEC_T_NVHL_NS)
)
(
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg  [15:0] dev_addr_o,
    output reg  [7:0]  dev_wdata_o,
    output reg         dev_we_o,
    output reg         dev_re_o,
    input  wire [7:0]  dev_rdata_i
);

    // ======================================================================
    // Timing counts
    localparam [31:0] C_NVS  = `FPEC_CYC(`FPEC_T_NVS_NS);
    localparam [31:0] C_NVH  = `FPEC_CYC(`FPEC_T_NVH_NS);
    localparam [31:0] C_PGS  = `FPEC_CYC(`FPEC_T_PGS_NS);
    localparam [31:0] C_PROG = `FPEC_CYC(`FPEC_BYTE_PROGRAM_TIME_NS);
    localparam [31:0] C_RCV  = `FPEC_CYC(`FPEC_T_RCV_NS);
    localparam [31:0] C_ER   = T_ERASE_CYC;
    localparam [31:0] C_MER  = T_MERASE_CYC;
    localparam [31:0] C_NVHL = T_NVHL_CYC;

    // ======================================================================
    // States
    localparam [4:0] S_IDLE   = 5'h00;
    localparam [4:0] S_SEL    = 5'h01;
    localparam [4:0] S_RDBP   = 5'h02;
    localparam [4:0] S_CHKBP  = 5'h03;
    localparam [4:0] S_RDCUR  = 5'h04;
    localparam [4:0] S_CHKCUR = 5'h05;
    localparam [4:0] S_LATCH  = 5'h06;
    localparam [4:0] S_NVS    = 5'h07;
    localparam [4:0] S_HVON   = 5'h08;
    localparam [4:0] S_HOLD   = 5'h09;
    localparam [4:0] S_BYTE   = 5'h0A;
    localparam [4:0] S_PROG   = 5'h0B;
    localparam [4:0] S_NEXT   = 5'h0C;
    localparam [4:0] S_DESEL  = 5'h0D;
    localparam [4:0] S_NVH    = 5'h0E;
    localparam [4:0] S_HVOFF  = 5'h0F;
    localparam [4:0] S_RCV    = 5'h10;
    localparam [4:0] S_ABORT  = 5'h11;

    // ======================================================================
    // Helpers
    function [15:0] fpec_protect_start;
        input [7:0] bits;
        begin
            fpec_protect_start = {2'b11, bits, 6'h00};
        end
    endfunction

    function fpec_is_array;
        input [15:0] a;
        begin
            fpec_is_array = (a >= `FPEC_ARRAY_BASE)
                && !(a >= `FPEC_VEC_RSVD_LO && a <= `FPEC_VEC_RSVD_HI)
                && (a != `FPEC_FLASH_CONTROL_ADDR)
                && (a != `FPEC_PROTECT_START_ADDR);
        end
    endfunction

    // ======================================================================
    // Registers
    reg [1:0]  cmd;
    reg [15:0] tgt_addr;
    reg [7:0]  row_data [0:31];
    reg [31:0] row_mask;
    reg        busy;
    reg        done;
    reg        refused;
    reg        need_blank;
    reg [4:0]  state;
    reg [31:0] wait_cnt;
    reg [4:0]  byte_idx;
    reg [7:0]  ctl_shadow;
    reg [7:0]  protect_bits;
    reg        start;

    wire       wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       wb_wr    = wb_req & wb_we_i & wb_sel_i[0];
    wire [15:0] row_base = {tgt_addr[15:5], 5'h00};
    wire [15:0] byte_addr = {tgt_addr[15:5], byte_idx};
    wire       wait_done = (wait_cnt == 32'h00000000);

    // ======================================================================
    // Wishbone slave, one registered ack per request, one cycle after it
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            case (wb_adr_i)
                `FPEC_REG_CMD:  wb_dat_o <= {30'h00000000, cmd};
                `FPEC_REG_ADDR: wb_dat_o <= {16'h0000, tgt_addr};
                `FPEC_REG_DATA: wb_dat_o <= row_mask;
                `FPEC_REG_STAT: wb_dat_o <= {16'h0000, protect_bits, 4'h0,
                                    need_blank, refused, done, busy};
                default:        wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // Row buffer: data register write stores byte at tgt_addr[4:0]
    always @(posedge clk_i)
    begin
        if (wb_wr && !busy && wb_adr_i == `FPEC_REG_DATA)
            row_data[tgt_addr[4:0]] <= wb_dat_i[7:0];
    end

    // ======================================================================
    // Sequencer, runs without array code or interrupts
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cmd          <= 2'h0;
            tgt_addr     <= 16'h0000;
            row_mask     <= 32'h00000000;
            busy         <= 1'b0;
            done         <= 1'b0;
            refused      <= 1'b0;
            need_blank   <= 1'b0;
            state        <= S_IDLE;
            wait_cnt     <= 32'h00000000;
            byte_idx     <= 5'h00;
            ctl_shadow   <= 8'h00;
            protect_bits <= `FPEC_PROTECT_OPEN;
            start        <= 1'b0;
            dev_addr_o   <= 16'h0000;
            dev_wdata_o  <= 8'h00;
            dev_we_o     <= 1'b0;
            dev_re_o     <= 1'b0;
        end
        else
        begin
            dev_we_o <= 1'b0;
            dev_re_o <= 1'b0;
            start    <= 1'b0;
            if (!wait_done)
                wait_cnt <= wait_cnt - 32'h00000001;
            if (wb_wr && !busy)
            begin
                case (wb_adr_i)
                    `FPEC_REG_CMD:
                    begin
                        cmd   <= wb_dat_i[1:0];
                        start <= (wb_dat_i[1:0] != 2'h0);
                    end
                    `FPEC_REG_ADDR:
                        tgt_addr <= wb_dat_i[15:0];
                    `FPEC_REG_DATA:
                        row_mask[tgt_addr[4:0]] <= 1'b1;
                    `FPEC_REG_STAT:
                    begin
                        done       <= done & ~wb_dat_i[`FPEC_ST_DONE];
                        refused    <= refused & ~wb_dat_i[`FPEC_ST_REFUSED];
                        need_blank <= need_blank & ~wb_dat_i[`FPEC_ST_NEED];
                    end
                    default:
                        cmd <= cmd;
                endcase
            end
            case (state)
                S_IDLE:
                    if (start)
                    begin
                        busy       <= 1'b1;
                        byte_idx   <= 5'h00;
                        ctl_shadow <= 8'h00;
                        if (cmd == `FPEC_CMD_PROGRAM)
                            ctl_shadow[`FPEC_BIT_PGM] <= 1'b1;
                        else
                        begin
                            ctl_shadow[`FPEC_BIT_ERASE] <= 1'b1;
                            ctl_shadow[`FPEC_BIT_MASS] <=
                                (cmd == `FPEC_CMD_MASS_ERASE);
                        end
                        state <= S_SEL;
                    end
                S_SEL:
                begin
                    dev_addr_o  <= `FPEC_FLASH_CONTROL_ADDR;
                    dev_wdata_o <= ctl_shadow;
                    dev_we_o    <= 1'b1;
                    state       <= S_RDBP;
                end
                S_RDBP:
                begin
                    dev_addr_o <= `FPEC_PROTECT_START_ADDR;
                    dev_re_o   <= 1'b1;
                    state      <= S_CHKBP;
                end
                S_CHKBP:
                    if (!dev_re_o)
                    begin
                        protect_bits <= dev_rdata_i;
                        if (cmd == `FPEC_CMD_MASS_ERASE && dev_rdata_i != `FPEC_PROTECT_OPEN)
                            state <= S_ABORT;
                        else if (cmd != `FPEC_CMD_MASS_ERASE
                                 && tgt_addr >= fpec_protect_start(dev_rdata_i)
                                 && dev_rdata_i != `FPEC_PROTECT_OPEN)
                            state <= S_ABORT;
                        else if (!fpec_is_array(tgt_addr))
                            state <= S_ABORT;
                        else if (cmd == `FPEC_CMD_PROGRAM)
                            state <= S_RDCUR;
                        else
                            state <= S_LATCH;
                    end
                S_RDCUR:
                begin
                    if (!row_mask[byte_idx])
                    begin
                        byte_idx <= byte_idx + 5'h01;
                        if (byte_idx == 5'h1F)
                            state <= S_LATCH;
                    end
                    else
                    begin
                        dev_addr_o <= byte_addr;
                        dev_re_o   <= 1'b1;
                        state      <= S_CHKCUR;
                    end
                end
                S_CHKCUR:
                    if (!dev_re_o)
                    begin
                        if (dev_rdata_i != `FPEC_ERASED_BYTE)
                        begin
                            need_blank <= 1'b1;
                            state      <= S_ABORT;
                        end
                        else
                        begin
                            byte_idx <= byte_idx + 5'h01;
                            state    <= (byte_idx == 5'h1F) ? S_LATCH : S_RDCUR;
                        end
                    end
                S_LATCH:
                begin
                    // First array write latches page or row
                    dev_addr_o  <= (cmd == `FPEC_CMD_PROGRAM) ? row_base
                                 : (cmd == `FPEC_CMD_MASS_ERASE) ? `FPEC_PROTECT_START_ADDR
                                 : {tgt_addr[15:6], 6'h00};
                    dev_wdata_o <= 8'h00;
                    dev_we_o    <= 1'b1;
                    byte_idx    <= 5'h00;
                    wait_cnt    <= C_NVS;
                    state       <= S_NVS;
                end
                S_NVS:
                    if (wait_done)
                    begin
                        ctl_shadow[`FPEC_BIT_HIGH_VOLTAGE_ENABLE] <= 1'b1;
                        state <= S_HVON;
                    end
                S_HVON:
                begin
                    dev_addr_o  <= `FPEC_FLASH_CONTROL_ADDR;
                    dev_wdata_o <= ctl_shadow;
                    dev_we_o    <= 1'b1;
                    wait_cnt    <= (cmd == `FPEC_CMD_PROGRAM) ? C_PGS
                                 : (cmd == `FPEC_CMD_MASS_ERASE) ? C_MER : C_ER;
                    state       <= S_HOLD;
                end
                S_HOLD:
                    if (wait_done)
                        state <= (cmd == `FPEC_CMD_PROGRAM) ? S_BYTE : S_DESEL;
                S_BYTE:
                begin
                    if (row_mask[byte_idx])
                    begin
                        dev_addr_o  <= byte_addr;
                        dev_wdata_o <= row_data[byte_idx];
                        dev_we_o    <= 1'b1;
                        wait_cnt    <= C_PROG;
                        state       <= S_PROG;
                    end
                    else
                        state <= S_NEXT;
                end
                S_PROG:
                    if (wait_done)
                        state <= S_NEXT;
                S_NEXT:
                begin
                    byte_idx <= byte_idx + 5'h01;
                    state    <= (byte_idx == 5'h1F) ? S_DESEL : S_BYTE;
                end
                S_DESEL:
                begin
                    ctl_shadow  <= 8'h00 | (8'h01 << `FPEC_BIT_HIGH_VOLTAGE_ENABLE);
                    dev_addr_o  <= `FPEC_FLASH_CONTROL_ADDR;
                    dev_wdata_o <= 8'h00 | (8'h01 << `FPEC_BIT_HIGH_VOLTAGE_ENABLE);
                    dev_we_o    <= 1'b1;
                    wait_cnt    <= (cmd == `FPEC_CMD_MASS_ERASE) ? C_NVHL : C_NVH;
                    state       <= S_NVH;
                end
                S_NVH:
                    if (wait_done)
                        state <= S_HVOFF;
                S_HVOFF:
                begin
                    ctl_shadow  <= 8'h00;
                    dev_addr_o  <= `FPEC_FLASH_CONTROL_ADDR;
                    dev_wdata_o <= 8'h00;
                    dev_we_o    <= 1'b1;
                    wait_cnt    <= C_RCV;
                    state       <= S_RCV;
                end
                S_RCV:
                    if (wait_done)
                    begin
                        busy     <= 1'b0;
                        done     <= 1'b1;
                        row_mask <= 32'h00000000;
                        state    <= S_IDLE;
                    end
                S_ABORT:
                begin
                    refused     <= 1'b1;
                    ctl_shadow  <= 8'h00;
                    dev_addr_o  <= `FPEC_FLASH_CONTROL_ADDR;
                    dev_wdata_o <= 8'h00;
                    dev_we_o    <= 1'b1;
                    busy        <= 1'b0;
                    row_mask    <= 32'h00000000;
                    state       <= S_IDLE;
                end
                default:
                    state <= S_IDLE;
            endcase
        end
    end

endmodule

// [dv/fpec_host_asserts.sv]
`timescale 1ns/1ps
module fpec_host_asserts
#(
    parameter T_ERASE_CYC  = 40000,
    parameter T_MERASE_CYC = 160000
)
(
    input wire        clk_i,
    input wire        rst_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_ack_o,
    input wire [15:0] dev_addr_o,
    input wire [7:0]  dev_wdata_o,
    input wire        dev_we_o,
    input wire        dev_re_o,
    input wire [7:0]  dev_rdata_i
);
    localparam NVS_CYC = 400;
    reg  [3:0]  sh;
    reg         pr;
    reg         lt;
    reg         rd_pend;
    reg  [7:0]  pv;
    reg  [15:0] lat;
    reg  [15:0] since_lat;
    reg  [19:0] hv_cnt;
    wire        cw = dev_we_o && dev_addr_o == 16'hFE08;
    wire        aw = dev_we_o && !cw && dev_addr_o[15:13] == 3'b111;
    wire        hv_up = cw && dev_wdata_o[3] && !sh[3];

    // ====================
    // Device step tracking
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sh <= 4'h0;
            pr <= 1'b0;
            lt <= 1'b0;
            rd_pend <= 1'b0;
            pv <= 8'h00;
            lat <= 16'h0000;
            since_lat <= 16'h0000;
            hv_cnt <= 20'h00000;
        end
        else
        begin
            rd_pend <= dev_re_o && dev_addr_o == 16'hFF7E;
            if (rd_pend)
            begin
                pr <= 1'b1;
                pv <= dev_rdata_i;
            end
            if (cw)
                sh <= dev_wdata_o[3:0];
            if (cw && dev_wdata_o[1:0] == 2'b00)
            begin
                pr <= 1'b0;
                lt <= 1'b0;
            end
            if (aw && !lt && sh[1:0] != 2'b00)
            begin
                lt <= 1'b1;
                lat <= dev_addr_o;
            end
            if (aw && !lt)
                since_lat <= 16'h0000;
            else if (!(&since_lat))
                since_lat <= since_lat + 16'h0001;
            if (hv_up)
                hv_cnt <= 20'h00000;
            else if (!(&hv_cnt))
                hv_cnt <= hv_cnt + 20'h00001;
        end
    end

    // ====================
    // Properties
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_sel_excl: assert property (cw |-> !(dev_wdata_o[0] && dev_wdata_o[1]))
        else $error("erase and program selected together");
    chk_hv_select: assert property (hv_up |-> sh[1:0] != 2'b00 && dev_wdata_o[1:0] == sh[1:0])
        else $error("high voltage without select");
    chk_hv_order: assert property (hv_up |-> pr && lt)
        else $error("high voltage before protect read or latch write");
    chk_nvs_wait: assert property (hv_up |-> since_lat >= NVS_CYC - 1)
        else $error("setup wait too short");
    chk_mass_open: assert property (hv_up && sh[2] |-> pv == 8'hFF)
        else $error("mass erase while protected");
    chk_hv_protect: assert property (hv_up |-> pv == 8'hFF || lat < {2'b11, pv, 6'h00})
        else $error("high voltage on protected target");
    chk_row_same: assert property (aw && lt && sh[3] |-> dev_addr_o[15:5] == lat[15:5])
        else $error("program write outside row");
    chk_erase_hold: assert property (cw && sh[3] && sh[1] && !dev_wdata_o[1]
        |-> hv_cnt + 1 >= (sh[2] ? T_MERASE_CYC : T_ERASE_CYC))
        else $error("erase time too short");
    chk_reset_idle: assert property ($fell(rst_i) |-> !dev_we_o && !dev_re_o && !wb_ack_o)
        else $error("outputs active after reset");
    cover property (hv_up && sh[2]);
    cover property (hv_up && sh[0]);
    cover property (aw && lt && sh[3]);
endmodule

// [dv/fpec_flash_model.sv]
`timescale 1ns/1ps
module fpec_flash_model
(
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [15:0] addr_i,
    input  wire [7:0]  wdata_i,
    input  wire        we_i,
    input  wire        re_i,
    output reg  [7:0]  rdata_o
);
    reg  [7:0]  mem [0:8191];
    reg  [3:0]  ctl;
    reg  [15:0] lat;
    reg         pr_rd;
    reg         lat_ok;
    integer     i;
    wire [7:0]  prot = mem[13'h1F7E];
    wire        blk = prot != 8'hFF && lat >= {2'b11, prot, 6'h00};
    wire        ok = pr_rd && lat_ok && !blk && !(ctl[2] && prot != 8'hFF);

    initial
    begin
        rdata_o = 8'h00;
        for (i = 0; i < 8192; i = i + 1)
            mem[i] = 8'hFF;
    end

    // ====================
    // Array and control; no internal timing
    always @(posedge clk_i)
    begin
        rdata_o <= re_i ? (addr_i == 16'hFE08 ? {4'h0, ctl} : mem[addr_i[12:0]]) : ~rdata_o;
        if (rst_i)
        begin
            ctl <= 4'h0;
            pr_rd <= 1'b0;
            lat_ok <= 1'b0;
        end
        else if (re_i && addr_i == 16'hFF7E && ctl[1:0] != 2'b00)
            pr_rd <= 1'b1;
        else if (we_i && addr_i == 16'hFE08 && !(wdata_i[0] && wdata_i[1]))
        begin
            ctl <= {wdata_i[3] && (ctl[3] || ok), wdata_i[2:0]};
            if (ctl[3] && ctl[1] && !wdata_i[1])
                for (i = 0; i < 8192; i = i + 1)
                    if (ctl[2] || i[12:6] == lat[12:6])
                        mem[i] <= 8'hFF;
            if (wdata_i[1:0] == 2'b00)
            begin
                pr_rd <= 1'b0;
                lat_ok <= 1'b0;
            end
        end
        else if (we_i && addr_i[15:13] == 3'b111 && ctl[1:0] != 2'b00)
        begin
            if (!lat_ok)
            begin
                lat <= addr_i;
                lat_ok <= 1'b1;
            end
            else if (ctl[3] && ctl[0] && addr_i[15:5] == lat[15:5])
                mem[addr_i[12:0]] <= mem[addr_i[12:0]] & wdata_i;
        end
    end
endmodule

// [dv/fpec_host_test.sv]
`timescale 1ns/1ps
module fpec_host_test;
    reg         clk_i = 1'b0;
    reg         rst_i = 1'b1;
    reg         cyc = 1'b0;
    reg  [3:0]  sel = 4'h0;
    reg         we = 1'b0;
    reg  [3:0]  adr = 4'h0;
    reg  [31:0] wdat = 32'h0;
    wire [31:0] rdat;
    wire        ack;
    wire [15:0] daddr;
    wire [7:0]  dwd;
    wire [7:0]  drd;
    wire        dwe;
    wire        dre;
    integer     n_fail = 0;
    integer     checks = 0;
    integer     seed = 67808;
    integer     i;
    reg  [31:0] r;
    reg  [31:0] st;
    reg  [31:0] msk;
    reg  [15:0] a;
    reg  [12:0] pb;
    reg  [12:0] rb;
    reg  [12:0] ix;
    reg  [7:0]  d [0:31];
    reg  [7:0]  sv [0:191];

    fpec_host #(.T_ERASE_CYC(20), .T_MERASE_CYC(40), .T_NVHL_CYC(10)) i_fpec_host (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .dev_addr_o(daddr), .dev_wdata_o(dwd), .dev_we_o(dwe), .dev_re_o(dre),
        .dev_rdata_i(drd));
    fpec_flash_model i_fpec_flash_model (.clk_i(clk_i), .rst_i(rst_i), .addr_i(daddr),
        .wdata_i(dwd), .we_i(dwe), .re_i(dre), .rdata_o(drd));

    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end

    // ====================
    // Tasks
    task complete_run;
        begin
            if (n_fail == 0 && checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp)
            begin
                n_fail = n_fail + 1;
                $display("ERROR %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task wbx(input w, input [3:0] ad, input [31:0] dt);
        begin
            @(posedge clk_i);
            cyc <= 1'b1;
            sel <= 4'hF;
            we <= w;
            adr <= ad;
            wdat <= dt;
            @(posedge clk_i);
            while (ack !== 1'b1)
                @(posedge clk_i);
            r = rdat;
            cyc <= 1'b0;
            sel <= 4'h0;
            we <= 1'b0;
        end
    endtask

    task run(input [1:0] c, input [15:0] ta);
        integer k;
        begin
            wbx(1'b1, 4'h4, {16'h0, ta});
            wbx(1'b1, 4'h0, {30'h0, c});
            st = 32'h0;
            for (k = 0; k < 20000 && st[2:1] == 2'b00; k = k + 1)
            begin
                wbx(1'b0, 4'hC, 32'h0);
                st = r;
            end
            wbx(1'b1, 4'hC, 32'hE);
        end
    endtask

    function [7:0] ex_prog(input integer k);
        ex_prog = (k[5] == rb[5] && msk[k[4:0]]) ? 8'hFF & d[k[4:0]] : 8'hFF;
    endfunction

    // ====================
    // Scenarios
    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wbx(1'b0, 4'hC, 32'h0);
        chk(r & 32'hF, 32'h0);
        wbx(1'b0, 4'h2, 32'h0);
        chk(r, 32'h0);
        a = 16'hE000 | ($random(seed) & 16'h1DFF);
        pb = a[12:0] & 13'h1FC0;
        for (i = 0; i < 192; i = i + 1)
        begin
            ix = pb - 13'd64 + i[12:0];
            sv[i] = $random(seed);
            i_fpec_flash_model.mem[ix] = sv[i];
        end
        run(2'h1, a);
        chk(st & 32'hFF07, 32'hFF02);
        for (i = 0; i < 192; i = i + 1)
        begin
            ix = pb - 13'd64 + i[12:0];
            chk({24'h0, i_fpec_flash_model.mem[ix]}, (i / 64 == 1) ? 32'hFF : sv[i]);
        end
        msk = $random(seed) | 32'h1;
        rb = pb | {7'h0, msk[31], 5'h0};
        for (i = 0; i < 32; i = i + 1)
        begin
            d[i] = $random(seed) & 8'h7F;
            if (msk[i])
            begin
                wbx(1'b1, 4'h4, {16'h0, 3'b111, rb | {8'h0, i[4:0]}});
                wbx(1'b1, 4'h8, {24'h0, d[i]});
            end
        end
        wbx(1'b0, 4'h8, 32'h0);
        chk(r, msk);
        run(2'h3, {3'b111, rb});
        chk(st & 32'hFF07, 32'hFF02);
        for (i = 0; i < 64; i = i + 1)
            chk({24'h0, i_fpec_flash_model.mem[pb | i[12:0]]}, {24'h0, ex_prog(i)});
        wbx(1'b1, 4'h4, {16'h0, 3'b111, rb});
        wbx(1'b1, 4'h8, 32'h0);
        run(2'h3, {3'b111, rb});
        chk(st & 32'hFF07, 32'hFF04);
        chk({24'h0, i_fpec_flash_model.mem[rb]}, {24'h0, d[0]});
        i_fpec_flash_model.mem[13'h1F7E] = 8'hF0;
        i_fpec_flash_model.mem[13'h1C40] = 8'h5A;
        run(2'h1, 16'hFC40);
        chk(st & 32'hFF07, 32'hF004);
        run(2'h2, a);
        chk(st & 32'hFF07, 32'hF004);
        chk({24'h0, i_fpec_flash_model.mem[13'h1C40]}, 32'h5A);
        run(2'h1, 16'hFBC0);
        chk(st & 32'hFF07, 32'hF002);
        i_fpec_flash_model.mem[13'h1F7E] = 8'hFF;
        run(2'h2, a);
        chk(st & 32'hFF07, 32'hFF02);
        wbx(1'b0, 4'h0, 32'h0);
        chk(r & 32'h3, 32'h2);
        chk({i_fpec_flash_model.mem[13'h1C40], i_fpec_flash_model.mem[rb]}, 32'hFFFF);
        wbx(1'b1, 4'h4, {16'h0, a});
        wbx(1'b1, 4'h0, 32'h1);
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wbx(1'b0, 4'hC, 32'h0);
        chk(r & 32'hF, 32'h0);
        chk({28'h0, i_fpec_flash_model.ctl}, 32'h0);
        complete_run;
    end

    initial
    begin
        #(25 * 100000);
        n_fail = n_fail + 1;
        complete_run;
    end
endmodule

bind fpec_host fpec_host_asserts #(.T_ERASE_CYC(T_ERASE_CYC), .T_MERASE_CYC(T_MERASE_CYC))
    i_fpec_host_asserts (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .dev_addr_o(dev_addr_o),
    .dev_wdata_o(dev_wdata_o), .dev_we_o(dev_we_o), .dev_re_o(dev_re_o),
    .dev_rdata_i(dev_rdata_i));
